// file: hdl/asp_pkg.sv
// Notes on behaviour
// - Dormant in multiprocessor modes: flag only after idle line, address bit or break.
// - Dormant in auto-baud mode: flag on a break, and on a synch field right after a break.
// - Not dormant: every received character sets the receive flag.
// - Bit order selectable, LSB first by default, both directions.
// - One or two stop bits by setting, one by default.
// - Mode field: plain, idle-line, address-bit, auto-baud; plain default.
// - Oversampling or low-frequency baud generation by a control bit.
// - Divider counts selected module clock, factor from prescaler field.
// - Two modulation stages stretch bit timing, held with oversampling bit.
// - Parity enable bit and odd/even select bit.
// - Configure under software reset; unit idle until reset released.
// - Status shows listen, errors, break, address, idle and busy.
// - Receive deglitch filter: 2, 50, 100 or 200 ns selectable.
// - Receive buffer read returns last received character as a byte.
// - Transmit and receive buffers at fixed addresses for DMA.
// - Transmit-address request marks next byte as address in address-bit mode only.
// - Four interrupt sources each enabled; only enabled ones raise request.
// - Reading the vector clears highest-priority pending flag.
// - Break request sends a break with next transmit-buffer write.
package asp_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_FRAME = 8'h00;
	localparam logic [7:0] OFS_UNIT = 8'h04;
	localparam logic [7:0] OFS_BAUD = 8'h08;
	localparam logic [7:0] OFS_MOD = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_RXBUF = 8'h14;
	localparam logic [7:0] OFS_TXBUF = 8'h18;
	localparam logic [7:0] OFS_IE = 8'h1C;
	localparam logic [7:0] OFS_IFG = 8'h20;
	localparam logic [7:0] OFS_IV = 8'h24;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_FRAME = 8'h00;
	localparam logic [7:0] RST_UNIT = 8'h01;
	localparam logic [15:0] RST_BAUD = 16'h0000;
	localparam logic [15:0] RST_MOD = 16'h0000;
	localparam logic [3:0] RST_IE = 4'h0;
	localparam logic [3:0] RST_IFG = 4'h2;
	// ==========================================================
	// Frame control bit positions
	localparam int FB_SYNC = 0;
	localparam int FB_MODE = 1;
	localparam int FB_SPB = 3;
	localparam int FB_SEVEN = 4;
	localparam int FB_MSB = 5;
	localparam int FB_PAR = 6;
	localparam int FB_PEN = 7;
	// Unit control bit positions
	localparam int UB_SWRST = 0;
	localparam int UB_TXBRK = 1;
	localparam int UB_TXADDR = 2;
	localparam int UB_DORM = 3;
	localparam int UB_LISTEN = 4;
	localparam int UB_DGL = 5;
	localparam int UB_SSEL = 7;
	// Modulation control: bit 0 oversampling, 7:4 first, 15:8 second
	localparam int MB_OS = 0;
	// Interrupt flag/enable bits
	localparam int IB_RX = 0;
	localparam int IB_TX = 1;
	localparam int IB_ERR = 2;
	localparam int IB_BRK = 3;
	// ==========================================================
	// Deglitch times and cycle counts at 250 MHz
	localparam int CLK_MHZ = 250;
	localparam int DGL_NS0 = 2;
	localparam int DGL_NS1 = 50;
	localparam int DGL_NS2 = 100;
	localparam int DGL_NS3 = 200;
	localparam int DGL_CY0 = (DGL_NS0 * CLK_MHZ + 999) / 1000;
	localparam int DGL_CY1 = (DGL_NS1 * CLK_MHZ + 999) / 1000;
	localparam int DGL_CY2 = (DGL_NS2 * CLK_MHZ + 999) / 1000;
	localparam int DGL_CY3 = (DGL_NS3 * CLK_MHZ + 999) / 1000;
	localparam int OS_TICKS = 16;
	localparam int IDLE_BITS = 10;
	localparam logic [7:0] SYNC_CHAR = 8'h55;

	typedef enum logic [1:0] {
		ASP_MODE_UART,
		ASP_MODE_IDLE,
		ASP_MODE_ADDR,
		ASP_MODE_ABAUD
	} asp_mode_t;

	typedef enum logic [1:0] {
		ASP_SSEL_EXT,
		ASP_SSEL_ACLK,
		ASP_SSEL_SMCLK,
		ASP_SSEL_SMCLK2
	} asp_ssel_t;

	typedef struct packed {
		logic pen;
		logic par_odd;
		logic msb;
		logic seven;
		logic two_stop;
		asp_mode_t mode;
		logic sync;
	} asp_frame_t;

	typedef struct packed {
		logic [7:0] data;
		logic addr;
		logic brk;
	} asp_txreq_t;
endpackage : asp_pkg

// file: hdl/asp_uart.sv
module asp_uart (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clk_ext,
	input wire logic clk_aux,
	input wire logic rxd,
	output logic txd,
	output logic irq
);
	// ==========================================================
	// Bus decode
	logic wr;
	logic rd;
	asp_pkg::asp_frame_t frame_ff;
	logic [8:0] unit_ff;
	logic [15:0] baud_ff;
	logic [15:0] mod_ff;
	logic [3:0] ie_ff;
	logic [3:0] ifg_ff;
	logic [7:0] rxbuf_ff;
	logic fe_ff, oe_ff, pe_ff, brk_ff, addr_rx_ff, idle_ff;
	logic swrst;
	logic rx_done;
	logic [7:0] rx_char;
	logic rx_fe, rx_pe, rx_brk, rx_addr, rx_take;
	logic tx_busy, rx_busy, tx_load;
	asp_pkg::asp_txreq_t txh_ff;
	logic txh_valid_ff;
	logic iv_rd;
	logic [3:0] iv_clr;

	assign pready = 1'b1;
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign swrst = unit_ff[asp_pkg::UB_SWRST];

	function automatic logic known(input logic [7:0] a);
		known = (a <= asp_pkg::OFS_IV) && (a[1:0] == 2'b00);
	endfunction : known
	assign pslverr = psel & penable & ~known(paddr);

	// ==========================================================
	// Registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			frame_ff <= asp_pkg::RST_FRAME;
			unit_ff <= {1'b0, asp_pkg::RST_UNIT};
			baud_ff <= asp_pkg::RST_BAUD;
			mod_ff <= asp_pkg::RST_MOD;
			ie_ff <= asp_pkg::RST_IE;
		end else if (wr) begin
			if (paddr == asp_pkg::OFS_FRAME && swrst)
				frame_ff <= pwdata[7:0];
			if (paddr == asp_pkg::OFS_UNIT)
				unit_ff <= pwdata[8:0];
			if (paddr == asp_pkg::OFS_BAUD && swrst)
				baud_ff <= pwdata[15:0];
			if (paddr == asp_pkg::OFS_MOD && swrst)
				mod_ff <= pwdata[15:0];
			if (paddr == asp_pkg::OFS_IE)
				ie_ff <= pwdata[3:0];
			if (paddr == asp_pkg::OFS_TXBUF) begin
				unit_ff[asp_pkg::UB_TXBRK] <= 1'b0;
				unit_ff[asp_pkg::UB_TXADDR] <= 1'b0;
			end
		end
	end

	// Vector: lowest set bit index wins (rx highest priority)
	assign iv_rd = rd && paddr == asp_pkg::OFS_IV;
	always_comb begin
		iv_clr = 4'h0;
		if (iv_rd) begin
			if (ifg_ff[0]) iv_clr = 4'h1;
			else if (ifg_ff[1]) iv_clr = 4'h2;
			else if (ifg_ff[2]) iv_clr = 4'h4;
			else if (ifg_ff[3]) iv_clr = 4'h8;
		end
	end

	assign rx_take = rd && paddr == asp_pkg::OFS_RXBUF;
	logic tx_wr;
	assign tx_wr = wr && paddr == asp_pkg::OFS_TXBUF && !swrst;

	// Flags: hardware set wins over software clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n || swrst) begin
			ifg_ff <= asp_pkg::RST_IFG;
		end else begin
			ifg_ff[asp_pkg::IB_RX] <= rx_done |
				(ifg_ff[0] & ~rx_take & ~iv_clr[0]
				& ~(wr && paddr == asp_pkg::OFS_IFG && !pwdata[0]));
			ifg_ff[asp_pkg::IB_TX] <= tx_load |
				(ifg_ff[1] & ~tx_wr & ~iv_clr[1]
				& ~(wr && paddr == asp_pkg::OFS_IFG && !pwdata[1]));
			ifg_ff[asp_pkg::IB_ERR] <= (rx_done & (rx_fe | rx_pe)) |
				(ifg_ff[2] & ~iv_clr[2]
				& ~(wr && paddr == asp_pkg::OFS_IFG && !pwdata[2]));
			ifg_ff[asp_pkg::IB_BRK] <= (rx_done & rx_brk) |
				(ifg_ff[3] & ~iv_clr[3]
				& ~(wr && paddr == asp_pkg::OFS_IFG && !pwdata[3]));
		end
	end
	assign irq = |(ifg_ff & ie_ff);

	// Receive status and buffer
	always_ff @(posedge ref_clk) begin
		if (!rst_n || swrst) begin
			rxbuf_ff <= 8'h00;
			fe_ff <= 1'b0;
			pe_ff <= 1'b0;
			oe_ff <= 1'b0;
			brk_ff <= 1'b0;
			addr_rx_ff <= 1'b0;
		end else if (rx_done) begin
			rxbuf_ff <= rx_char;
			fe_ff <= rx_fe;
			pe_ff <= rx_pe;
			brk_ff <= rx_brk;
			addr_rx_ff <= rx_addr;
			oe_ff <= oe_ff | (ifg_ff[0] & ~rx_take);
		end else if (rx_take) begin
			fe_ff <= 1'b0;
			pe_ff <= 1'b0;
			oe_ff <= 1'b0;
			brk_ff <= 1'b0;
			addr_rx_ff <= 1'b0;
		end
	end

	always_comb begin
		prdata = 32'h0000_0000;
		if (rd) begin
			unique case (paddr)
				asp_pkg::OFS_FRAME: prdata[7:0] = frame_ff;
				asp_pkg::OFS_UNIT: prdata[8:0] = unit_ff;
				asp_pkg::OFS_BAUD: prdata[15:0] = baud_ff;
				asp_pkg::OFS_MOD: prdata[15:0] = mod_ff;
				asp_pkg::OFS_STAT: prdata[7:0] = {
					unit_ff[asp_pkg::UB_LISTEN], fe_ff, oe_ff, pe_ff,
					brk_ff, fe_ff | oe_ff | pe_ff | brk_ff,
					addr_rx_ff | idle_ff, tx_busy | rx_busy};
				asp_pkg::OFS_RXBUF: prdata[7:0] = rxbuf_ff;
				asp_pkg::OFS_IE: prdata[3:0] = ie_ff;
				asp_pkg::OFS_IFG: prdata[3:0] = ifg_ff;
				asp_pkg::OFS_IV: prdata[3:0] = {iv_clr[3] | iv_clr[2],
					iv_clr[1] | iv_clr[2], iv_clr[0] | iv_clr[1], 1'b0};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Clock source select: external clocks sampled as tick enables
	logic [1:0] ext_s_ff, aux_s_ff;
	logic ext_q_ff, aux_q_ff;
	logic src_tick;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ext_s_ff <= 2'b00;
			aux_s_ff <= 2'b00;
			ext_q_ff <= 1'b0;
			aux_q_ff <= 1'b0;
		end else begin
			ext_s_ff <= {ext_s_ff[0], clk_ext};
			aux_s_ff <= {aux_s_ff[0], clk_aux};
			ext_q_ff <= ext_s_ff[1];
			aux_q_ff <= aux_s_ff[1];
		end
	end
	always_comb begin
		unique case (asp_pkg::asp_ssel_t'(unit_ff[asp_pkg::UB_SSEL +: 2]))
			asp_pkg::ASP_SSEL_EXT: src_tick = ext_s_ff[1] & ~ext_q_ff;
			asp_pkg::ASP_SSEL_ACLK: src_tick = aux_s_ff[1] & ~aux_q_ff;
			asp_pkg::ASP_SSEL_SMCLK: src_tick = 1'b1;
			asp_pkg::ASP_SSEL_SMCLK2: src_tick = 1'b1;
		endcase
	end

	// Baud generator: returns ticks per bit, or per sample when oversampling
	function automatic logic [15:0] bit_len(input logic [15:0] pre,
		input logic [3:0] frac, input logic [7:0] smod, input logic [2:0] idx,
		input logic os);
		logic [15:0] base;
		base = (pre == 16'h0000) ? 16'h0001 : pre;
		bit_len = base + {15'h0000, smod[idx]};
		if (os)
			bit_len = bit_len + {15'h0000, (frac != 4'h0) && idx[0]};
	endfunction : bit_len

	// ==========================================================
	// Receive deglitch filter
	logic [1:0] rx_s_ff;
	logic rxf_ff;
	logic rxf_q_ff;
	logic [5:0] dgl_cnt_ff;
	logic [5:0] dgl_lim;
	always_comb begin
		unique case (unit_ff[asp_pkg::UB_DGL +: 2])
			2'd0: dgl_lim = 6'(asp_pkg::DGL_CY0);
			2'd1: dgl_lim = 6'(asp_pkg::DGL_CY1);
			2'd2: dgl_lim = 6'(asp_pkg::DGL_CY2);
			2'd3: dgl_lim = 6'(asp_pkg::DGL_CY3);
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_s_ff <= 2'b11;
			rxf_ff <= 1'b1;
			rxf_q_ff <= 1'b1;
			dgl_cnt_ff <= 6'h00;
		end else begin
			rx_s_ff <= {rx_s_ff[0], rxd};
			rxf_q_ff <= rxf_ff;
			if (rx_s_ff[1] == rxf_ff)
				dgl_cnt_ff <= 6'h00;
			else if (dgl_cnt_ff + 6'h01 >= dgl_lim) begin
				rxf_ff <= rx_s_ff[1];
				dgl_cnt_ff <= 6'h00;
			end else
				dgl_cnt_ff <= dgl_cnt_ff + 6'h01;
		end
	end

	// ==========================================================
	// Shared frame helpers
	function automatic logic [3:0] nbits(input asp_pkg::asp_frame_t f);
		nbits = 4'd8 - {3'h0, f.seven} + {3'h0, f.pen}
			+ {3'h0, f.mode == asp_pkg::ASP_MODE_ADDR};
	endfunction : nbits

	// ==========================================================
	// Transmitter
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} asp_txst_t;
	asp_txst_t tx_st_ff;
	logic [11:0] tx_sh_ff;
	logic [3:0] tx_left_ff;
	logic [15:0] tx_cnt_ff;
	logic [2:0] tx_idx_ff;
	logic txd_ff;
	logic [15:0] tx_len;
	logic [7:0] tx_ord;
	logic tx_par;
	logic [3:0] tx_tail;
	logic [11:0] tx_frame;

	assign tx_len = bit_len(baud_ff, mod_ff[7:4], mod_ff[15:8], tx_idx_ff,
		mod_ff[asp_pkg::MB_OS]) << (mod_ff[asp_pkg::MB_OS] ? 4 : 0);
	assign tx_busy = txh_valid_ff | (tx_st_ff != TX_IDLE);
	assign tx_load = txh_valid_ff && tx_st_ff == TX_IDLE;
	assign txd = txd_ff;
	assign tx_ord = frame_ff.msb ? (8'({<<{txh_ff.data}}) >> frame_ff.seven)
		: txh_ff.data;
	assign tx_par = (^(frame_ff.seven ? {1'b0, txh_ff.data[6:0]} :
		txh_ff.data)) ^ frame_ff.par_odd;

	// Line order after the data bits: address bit, parity, stop bits
	always_comb begin
		tx_tail = 4'hF;
		if (frame_ff.mode == asp_pkg::ASP_MODE_ADDR) begin
			tx_tail = frame_ff.pen ? {2'b11, tx_par, txh_ff.addr}
				: {3'b111, txh_ff.addr};
		end else if (frame_ff.pen) begin
			tx_tail = {3'b111, tx_par};
		end
		tx_frame = frame_ff.seven ? {1'b1, tx_tail, tx_ord[6:0]}
			: {tx_tail, tx_ord};
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n || swrst) begin
			txh_valid_ff <= 1'b0;
			txh_ff <= '0;
		end else if (tx_wr) begin
			txh_valid_ff <= 1'b1;
			txh_ff <= {pwdata[7:0], unit_ff[asp_pkg::UB_TXADDR],
				unit_ff[asp_pkg::UB_TXBRK]};
		end else if (tx_load)
			txh_valid_ff <= 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n || swrst) begin
			tx_st_ff <= TX_IDLE;
			txd_ff <= 1'b1;
			tx_sh_ff <= 12'hFFF;
			tx_left_ff <= 4'h0;
			tx_cnt_ff <= 16'h0000;
			tx_idx_ff <= 3'h0;
		end else unique case (tx_st_ff)
			TX_IDLE: if (tx_load) begin
				tx_st_ff <= TX_SHIFT;
				txd_ff <= 1'b0;
				tx_cnt_ff <= 16'h0000;
				tx_idx_ff <= 3'h0;
				if (txh_ff.brk) begin
					tx_sh_ff <= 12'h000;
					tx_left_ff <= 4'd11;
				end else begin
					tx_sh_ff <= tx_frame;
					tx_left_ff <= nbits(frame_ff)
						+ (frame_ff.two_stop ? 4'd2 : 4'd1);
				end
			end
			TX_SHIFT: if (src_tick) begin
				if (tx_cnt_ff + 16'h0001 >= tx_len) begin
					tx_cnt_ff <= 16'h0000;
					tx_idx_ff <= tx_idx_ff + 3'h1;
					if (tx_left_ff == 4'h0) begin
						tx_st_ff <= TX_IDLE;
						txd_ff <= 1'b1;
					end else begin
						txd_ff <= tx_sh_ff[0];
						tx_sh_ff <= {1'b1, tx_sh_ff[11:1]};
						tx_left_ff <= tx_left_ff - 4'h1;
					end
				end else
					tx_cnt_ff <= tx_cnt_ff + 16'h0001;
			end
			default: tx_st_ff <= TX_IDLE;
		endcase
	end

	// ==========================================================
	// Receiver
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asp_rxst_t;
	asp_rxst_t rx_st_ff;
	logic [15:0] rx_cnt_ff;
	logic [2:0] rx_idx_ff;
	logic [3:0] rx_left_ff;
	logic [10:0] rx_sh_ff;
	logic [3:0] idle_cnt_ff;
	logic sync_wait_ff;
	logic [15:0] rx_len;
	logic [7:0] rx_raw;
	logic rx_zero;
	logic rx_keep;
	logic [3:0] rx_apos;

	assign rx_len = bit_len(baud_ff, mod_ff[7:4], mod_ff[15:8], rx_idx_ff,
		mod_ff[asp_pkg::MB_OS]) << (mod_ff[asp_pkg::MB_OS] ? 4 : 0);
	assign rx_busy = rx_st_ff != RX_IDLE;
	assign rx_raw = 8'(rx_sh_ff >> (4'd11 - nbits(frame_ff)))
		& (frame_ff.seven ? 8'h7F : 8'hFF);
	assign rx_apos = 4'd11 - nbits(frame_ff)
		+ (frame_ff.seven ? 4'd7 : 4'd8);
	assign rx_char = frame_ff.msb ? ({<<{rx_raw}} >> frame_ff.seven) : rx_raw;
	assign rx_zero = (rx_sh_ff == 11'h000) && !rxf_ff;
	assign rx_brk = rx_zero;
	assign rx_fe = !rxf_ff && !rx_zero;
	assign rx_pe = frame_ff.pen && !rx_zero
		&& (^rx_sh_ff ^ frame_ff.par_odd ^ rx_addr) != 1'b0;
	assign rx_addr = frame_ff.mode == asp_pkg::ASP_MODE_ADDR
		&& rx_sh_ff[rx_apos];

	always_comb begin
		unique case (frame_ff.mode)
			asp_pkg::ASP_MODE_IDLE: rx_keep = idle_ff;
			asp_pkg::ASP_MODE_ADDR: rx_keep = rx_addr;
			asp_pkg::ASP_MODE_ABAUD: rx_keep = sync_wait_ff
				&& rx_char == asp_pkg::SYNC_CHAR;
			asp_pkg::ASP_MODE_UART: rx_keep = 1'b0;
		endcase
		if (!unit_ff[asp_pkg::UB_DORM])
			rx_keep = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n || swrst) begin
			rx_st_ff <= RX_IDLE;
			rx_cnt_ff <= 16'h0000;
			rx_idx_ff <= 3'h0;
			rx_left_ff <= 4'h0;
			rx_sh_ff <= 11'h000;
			rx_done <= 1'b0;
			idle_cnt_ff <= 4'h0;
			idle_ff <= 1'b0;
			sync_wait_ff <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			unique case (rx_st_ff)
				RX_IDLE: begin
					if (src_tick && rx_cnt_ff + 16'h0001 >= rx_len) begin
						rx_cnt_ff <= 16'h0000;
						if (idle_cnt_ff != 4'(asp_pkg::IDLE_BITS))
							idle_cnt_ff <= idle_cnt_ff + 4'h1;
					end else if (src_tick)
						rx_cnt_ff <= rx_cnt_ff + 16'h0001;
					if (rxf_q_ff && !rxf_ff) begin
						rx_st_ff <= RX_START;
						rx_cnt_ff <= 16'h0000;
						rx_idx_ff <= 3'h0;
						idle_ff <= idle_cnt_ff == 4'(asp_pkg::IDLE_BITS);
					end
				end
				RX_START: if (src_tick) begin
					if (rx_cnt_ff + 16'h0001 >= rx_len >> 1) begin
						rx_cnt_ff <= 16'h0000;
						rx_st_ff <= rxf_ff ? RX_IDLE : RX_DATA;
						rx_left_ff <= nbits(frame_ff);
						rx_sh_ff <= 11'h000;
					end else
						rx_cnt_ff <= rx_cnt_ff + 16'h0001;
				end
				RX_DATA, RX_STOP: if (src_tick) begin
					if (rx_cnt_ff + 16'h0001 >= rx_len) begin
						rx_cnt_ff <= 16'h0000;
						rx_idx_ff <= rx_idx_ff + 3'h1;
						if (rx_st_ff == RX_DATA) begin
							rx_sh_ff <= {rxf_ff, rx_sh_ff[10:1]};
							rx_left_ff <= rx_left_ff - 4'h1;
							if (rx_left_ff == 4'h1)
								rx_st_ff <= RX_STOP;
						end else begin
							rx_st_ff <= RX_IDLE;
							idle_cnt_ff <= 4'h0;
							if (rx_brk)
								sync_wait_ff <= 1'b1;
							else
								sync_wait_ff <= 1'b0;
							rx_done <= rx_keep || rx_brk;
						end
					end else
						rx_cnt_ff <= rx_cnt_ff + 16'h0001;
				end
			endcase
		end
	end
endmodule : asp_uart

// file: dv/asp_uart_props.sv
module asp_uart_props (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic clk_ext,
	input wire logic clk_aux,
	input wire logic rxd,
	input wire logic txd,
	input wire logic irq
);
	// ==========================================================
	// Shadow copies of the registers software has written
	logic wr_acc;
	logic rd_acc;
	logic [8:0] unit_ff;
	logic [7:0] frame_ff;
	logic [3:0] ie_ff;
	assign wr_acc = psel && penable && pwrite && pready;
	assign rd_acc = psel && penable && !pwrite;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			unit_ff <= {1'h0, asp_pkg::RST_UNIT};
		end else if (wr_acc && paddr == asp_pkg::OFS_UNIT) begin
			unit_ff <= pwdata[8:0];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			frame_ff <= asp_pkg::RST_FRAME;
		end else if (wr_acc && paddr == asp_pkg::OFS_FRAME && unit_ff[0]) begin
			frame_ff <= pwdata[7:0];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ie_ff <= asp_pkg::RST_IE;
		end else if (wr_acc && paddr == asp_pkg::OFS_IE) begin
			ie_ff <= pwdata[3:0];
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	a_ready_zero_wait: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0
		|-> pslverr == (paddr > asp_pkg::OFS_IV))
		else $error("slave error does not match address map");
	a_reset_idle: assert property ($rose(rst_n) |-> txd && !irq)
		else $error("line or request not idle after reset");
	a_swrst_quiet: assert property (unit_ff[0] && $past(unit_ff[0]) |-> txd)
		else $error("line active while held in software reset");
	a_irq_masked: assert property (ie_ff == 4'h0 && $past(ie_ff) == 4'h0
		|-> !irq)
		else $error("request raised with all sources disabled");
	a_rxbuf_byte: assert property (rd_acc && paddr == asp_pkg::OFS_RXBUF
		|-> prdata[31:8] == 24'h0)
		else $error("receive buffer read wider than a byte");
	a_frame_hold: assert property (rd_acc && paddr == asp_pkg::OFS_FRAME
		|-> prdata[7:0] == frame_ff)
		else $error("frame control readback differs");
	a_listen_stat: assert property (rd_acc && paddr == asp_pkg::OFS_STAT
		|-> prdata[7] == unit_ff[4])
		else $error("status listen bit differs from control");
	c_rx_read: cover property (rd_acc && paddr == asp_pkg::OFS_RXBUF);
	c_tx_start: cover property ($fell(txd));
	c_irq_rise: cover property ($rose(irq));
	c_slv_err: cover property (psel && penable && pslverr);
endmodule : asp_uart_props

bind asp_uart asp_uart_props asp_uart_props_i (
	.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .clk_ext(clk_ext),
	.clk_aux(clk_aux), .rxd(rxd), .txd(txd), .irq(irq)
);

// file: dv/asp_remote_node.sv
module asp_remote_node #(
	parameter int BIT_CY = 64
) (
	input wire logic ref_clk,
	input wire logic txd,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rxd = 1'h1;
	// Start bit, bits LSB of vector first, then one idle bit time high
	task automatic send(input logic [11:0] b, input int n);
		rxd <= 1'h0;
		repeat (BIT_CY) @(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			rxd <= b[i];
			repeat (BIT_CY) @(posedge ref_clk);
		end
		rxd <= 1'h1;
		repeat (BIT_CY) @(posedge ref_clk);
	endtask : send
	task automatic glitch(input int cy);
		rxd <= 1'h0;
		repeat (cy) @(posedge ref_clk);
		rxd <= 1'h1;
		@(posedge ref_clk);
	endtask : glitch
	// Samples each bit in its middle; unfilled positions read as one
	task automatic capture(input int n, output logic [11:0] b);
		int k;
		b = '1;
		k = 0;
		while (txd !== 1'h0 && k < 4000) begin
			@(posedge ref_clk);
			k++;
		end
		repeat (BIT_CY / 2) @(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			repeat (BIT_CY) @(posedge ref_clk);
			b[i] = txd;
		end
	endtask : capture
	task automatic low_time(output int cy);
		int k;
		k = 0;
		cy = 0;
		while (txd !== 1'h0 && k < 4000) begin
			@(posedge ref_clk);
			k++;
		end
		while (txd === 1'h0 && cy < 2000) begin
			@(posedge ref_clk);
			cy++;
		end
	endtask : low_time
endmodule : asp_remote_node

// file: dv/tb_async_serial_port_config.sv
module tb_async_serial_port_config;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BC = 64;
	typedef struct {
		logic [7:0] f;
		logic [7:0] d;
		logic [15:0] baud;
		logic [15:0] md;
	} asp_row_t;
	logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic rxd, txd, irq, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [11:0] bits;
	int cy;
	int mismatches = 0;
	int check_count = 0;
	asp_row_t rows [5] = '{
		'{8'h00, 8'hA5, 16'h0040, 16'h0000},
		'{8'h20, 8'h3C, 16'h0040, 16'h0000},
		'{8'h88, 8'h96, 16'h0040, 16'h0000},
		'{8'hD0, 8'h5B, 16'h0004, 16'h0001},
		'{8'h30, 8'h7E, 16'h0040, 16'h0000}};

	asp_uart asp_uart_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clk_ext(1'h0), .clk_aux(1'h0), .rxd(rxd), .txd(txd), .irq(irq));
	asp_remote_node #(.BIT_CY(BC)) asp_remote_node_i (.ref_clk(ref_clk),
		.txd(txd), .rxd(rxd));

	initial begin
		ref_clk = 1'h0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 100);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// Configuration is written only while the unit is held in reset
	task automatic cfg(input logic [7:0] f, input logic [8:0] u,
		input logic [15:0] b, input logic [15:0] m);
		apb(1'h1, asp_pkg::OFS_UNIT, {23'h0, u} | 32'h1);
		apb(1'h1, asp_pkg::OFS_FRAME, {24'h0, f});
		apb(1'h1, asp_pkg::OFS_BAUD, {16'h0, b});
		apb(1'h1, asp_pkg::OFS_MOD, {16'h0, m});
		apb(1'h1, asp_pkg::OFS_IE, 32'h1);
		apb(1'h1, asp_pkg::OFS_UNIT, {23'h0, u});
	endtask : cfg
	task automatic rx_take(input logic [7:0] d);
		int n;
		n = 0;
		while (irq !== 1'h1 && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
		chk({31'h0, irq}, 32'h1);
		apb(1'h0, asp_pkg::OFS_RXBUF, 32'h0);
		chk(r, {24'h0, d});
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
	endtask : rx_take
	function automatic int nbits(input logic [7:0] f);
		return (f[4] ? 7 : 8) + int'(f[7]) + (f[3] ? 2 : 1);
	endfunction : nbits
	function automatic logic [11:0] build(input logic [7:0] f,
		input logic [7:0] d);
		logic [11:0] b;
		int nd;
		b = '1;
		nd = f[4] ? 7 : 8;
		for (int i = 0; i < nd; i++) begin
			b[i] = f[5] ? d[nd - 1 - i] : d[i];
		end
		if (f[7]) begin
			b[nd] = (^(d & (f[4] ? 8'h7F : 8'hFF))) ^ f[6];
		end
		return b;
	endfunction : build

	initial begin
		repeat (50000) @(posedge ref_clk);
		mismatches++;
		conclude();
	end

	initial begin
		rst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 5; i++) begin
			cfg(rows[i].f, 9'h100, rows[i].baud, rows[i].md);
			apb(1'h1, asp_pkg::OFS_TXBUF, {24'h0, rows[i].d});
			asp_remote_node_i.capture(nbits(rows[i].f), bits);
			chk({20'h0, bits}, {20'h0, build(rows[i].f, rows[i].d)});
			asp_remote_node_i.send(build(rows[i].f, rows[i].d),
				nbits(rows[i].f));
			rx_take(rows[i].d & (rows[i].f[4] ? 8'h7F : 8'hFF));
		end
		// Dormant, idle-line mode
		cfg(8'h02, 9'h108, 16'h0040, 16'h0000);
		repeat (11 * BC) @(posedge ref_clk);
		asp_remote_node_i.send(build(8'h00, 8'h11), 9);
		rx_take(8'h11);
		asp_remote_node_i.send(build(8'h00, 8'h22), 9);
		repeat (3 * BC) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		repeat (11 * BC) @(posedge ref_clk);
		asp_remote_node_i.send(build(8'h00, 8'h33), 9);
		rx_take(8'h33);
		// Dormant, address-bit mode, then an address character sent
		cfg(8'h04, 9'h108, 16'h0040, 16'h0000);
		asp_remote_node_i.send({3'h7, 1'h0, 8'h44}, 10);
		repeat (2 * BC) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		asp_remote_node_i.send({3'h7, 1'h1, 8'h45}, 10);
		rx_take(8'h45);
		apb(1'h1, asp_pkg::OFS_UNIT, 32'h10C);
		apb(1'h1, asp_pkg::OFS_TXBUF, 32'hA7);
		asp_remote_node_i.capture(10, bits);
		chk({20'h0, bits}, {20'h0, 4'hF, 8'hA7});
		// Dormant, auto-baud mode: plain sync alone must stay silent
		cfg(8'h06, 9'h108, 16'h0040, 16'h0000);
		asp_remote_node_i.send(build(8'h00, 8'h55), 9);
		repeat (3 * BC) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		asp_remote_node_i.send(12'h000, 12);
		rx_take(8'h00);
		asp_remote_node_i.send(build(8'h00, 8'h55), 9);
		rx_take(8'h55);
		// Break transmit
		cfg(8'h00, 9'h100, 16'h0040, 16'h0000);
		apb(1'h1, asp_pkg::OFS_UNIT, 32'h102);
		apb(1'h1, asp_pkg::OFS_TXBUF, 32'h0);
		asp_remote_node_i.low_time(cy);
		chk(32'(cy / BC), 32'hC);
		// Longest deglitch time swallows a short pulse
		cfg(8'h00, 9'h160, 16'h0040, 16'h0000);
		asp_remote_node_i.glitch(40);
		repeat (11 * BC) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		asp_remote_node_i.send(build(8'h00, 8'hC3), 9);
		rx_take(8'hC3);
		// Refused frame write, unmapped access
		apb(1'h1, asp_pkg::OFS_FRAME, 32'hFF);
		apb(1'h0, asp_pkg::OFS_FRAME, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, 8'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		// Second reset and reset values
		rst_n <= 1'h0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h1;
		apb(1'h0, asp_pkg::OFS_FRAME, 32'h0);
		chk(r, {24'h0, asp_pkg::RST_FRAME});
		apb(1'h0, asp_pkg::OFS_UNIT, 32'h0);
		chk(r, {24'h0, asp_pkg::RST_UNIT});
		apb(1'h0, asp_pkg::OFS_IFG, 32'h0);
		chk(r, {28'h0, asp_pkg::RST_IFG});
		chk({31'h0, txd}, 32'h1);
		conclude();
	end
endmodule : tb_async_serial_port_config
